// file: rtl/clock_controller_freq_divider.sv
`timescale 1ns/1ps
`include "clkctl_params.svh"

module clock_controller_freq_divider
  import clkctl_pkg::*;
#(
  parameter int       MOD_NUM   = 8,
  parameter logic [7:0] KEEP_MASK = 8'h1f, // modules that may run on a slow source
  parameter src_sel_t SEL_X32   = 3'h1,
  parameter src_sel_t SEL_X12   = 3'h0,
  parameter src_sel_t SEL_PLL   = 3'h2,
  parameter src_sel_t SEL_O22   = 3'h7,
  parameter src_sel_t SEL_O10   = 3'h3
)(
  input  wire logic                       clk_i,
  input  wire logic                       rstn_i,
  input  wire logic [`SRC_NUM-1:0]        src_lvl_i,
  input  wire logic                       pll_ref_sel_i,
  input  wire logic [`SEL0_W-1:0]         clock_select_reg0_i,
  input  wire logic [`HDIV_W-1:0]         sys_div_i,
  input  wire logic [MOD_NUM-1:0]         mod_clk_en_i,
  input  wire logic [MOD_NUM-1:0]         mod_slow_src_i,
  input  wire logic                       pwr_down_bit_i,
  input  wire logic                       wait_for_interrupt_instr_i,
  input  wire logic                       wait_for_event_instr_i,
  input  wire logic                       wake_i,
  input  wire logic [`FDIV_CTRL_W-1:0]    divider_control_reg_i,
  input  wire logic [2:0]                 fdiv_src_sel_i,
  output logic                            x32_en_o,
  output logic                            x12_en_o,
  output logic                            pll_en_o,
  output logic                            o22_en_o,
  output logic                            o10_en_o,
  output logic                            pll_ref_o,
  output logic                            sys_clk_o,
  output logic                            tick_clock_o,
  output logic [MOD_NUM-1:0]              mod_clk_en_o,
  output logic                            pwr_down_o,
  output logic                            fdiv_out_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // map a select code to the level of that source, unknown code gives low
  function automatic logic src_pick(input src_sel_t sel, input logic [`SRC_NUM-1:0] lvl);
    logic res;
    res = 1'b0;
    if (sel == SEL_X32) res = lvl[`SRC_X32];
    if (sel == SEL_X12) res = lvl[`SRC_X12];
    if (sel == SEL_PLL) res = lvl[`SRC_PLL];
    if (sel == SEL_O22) res = lvl[`SRC_O22];
    if (sel == SEL_O10) res = lvl[`SRC_O10];
    return res;
  endfunction : src_pick

  // slow codes stay alive in power-down
  function automatic logic src_slow(input src_sel_t sel);
    return (sel == SEL_X32) || (sel == SEL_O10);
  endfunction : src_slow

  // ----------------------------------------------------------------
  // source level synchronisers
  // ----------------------------------------------------------------
  logic [`SRC_NUM-1:0] sync1_r;
  logic [`SRC_NUM-1:0] sync2_r;
  logic [`SRC_NUM-1:0] sync3_r;
  logic [`SRC_NUM-1:0] src_r;

  // three stages, a change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      src_r   <= '0;
    end
    else
    begin
      sync1_r <= src_lvl_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int i = 0; i < `SRC_NUM; i++)
        if (sync2_r[i] == sync3_r[i])
          src_r[i] <= sync3_r[i];
    end
  end

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  pwr_state_t pwr_r;
  logic       pd_entry;
  logic       slow_only;

  assign pd_entry = pwr_down_bit_i &
                    (wait_for_interrupt_instr_i | wait_for_event_instr_i);

  // run and power-down states
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pwr_r <= PWR_RUN;
    else
    begin
      unique case (pwr_r)
        PWR_RUN:  if (pd_entry) pwr_r <= PWR_DOWN;
        PWR_DOWN: if (wake_i)   pwr_r <= PWR_RUN;
      endcase
    end
  end

  assign slow_only = (pwr_r == PWR_DOWN);

  // ----------------------------------------------------------------
  // source enables and pll reference
  // ----------------------------------------------------------------
  // fast sources stop in power-down, slow ones never do
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      x32_en_o  <= 1'b1;
      o10_en_o  <= 1'b1;
      x12_en_o  <= 1'b1;
      o22_en_o  <= 1'b1;
      pll_en_o  <= 1'b1;
      pll_ref_o <= `PLL_REF_X12;
    end
    else
    begin
      x32_en_o  <= 1'b1;
      o10_en_o  <= 1'b1;
      x12_en_o  <= !slow_only;
      o22_en_o  <= !slow_only;
      pll_en_o  <= !slow_only;
      pll_ref_o <= pll_ref_sel_i;
    end
  end

  // ----------------------------------------------------------------
  // system clock with divider, tick clock
  // ----------------------------------------------------------------
  src_sel_t            sys_sel;
  src_sel_t            tick_sel;
  logic                sys_lvl;
  logic                sys_lvl_r;
  logic [`HDIV_W-1:0]  hcnt_r;

  assign sys_sel  = clock_select_reg0_i[`SYS_SEL_MSB:`SYS_SEL_LSB];
  assign tick_sel = clock_select_reg0_i[`TICK_SEL_MSB:`TICK_SEL_LSB];
  assign sys_lvl  = src_pick(sys_sel, src_r);

  // count source half periods, toggle after divisor plus one of them
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sys_lvl_r <= 1'b0;
      hcnt_r    <= '0;
      sys_clk_o <= 1'b0;
    end
    else
    begin
      sys_lvl_r <= sys_lvl;
      if (slow_only)
      begin
        hcnt_r    <= '0;
        sys_clk_o <= 1'b0;
      end
      else if (sys_lvl != sys_lvl_r)
      begin
        if (hcnt_r >= sys_div_i)
        begin
          hcnt_r    <= '0;
          sys_clk_o <= !sys_clk_o;
        end
        else
          hcnt_r <= hcnt_r + 1'b1;
      end
    end
  end

  // tick clock follows its source, off in power-down unless slow
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tick_clock_o <= 1'b0;
    else
      tick_clock_o <= src_pick(tick_sel, src_r) &
                      (!slow_only | src_slow(tick_sel));
  end

  // ----------------------------------------------------------------
  // module clock gates
  // ----------------------------------------------------------------
  // per-module enable, kept in power-down only on slow source
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      mod_clk_en_o <= '0;
    else
      mod_clk_en_o <= mod_clk_en_i & ({MOD_NUM{!slow_only}} |
                      (KEEP_MASK[MOD_NUM-1:0] & mod_slow_src_i));
  end

  assign pwr_down_o = slow_only;

  // ----------------------------------------------------------------
  // frequency divider
  // ----------------------------------------------------------------
  logic                     fin_lvl_r;
  logic                     fin_rise;
  logic                     fen;
  logic                     fen_r;
  logic                     frun_r;
  logic [`FDIV_STAGES-1:0]  chain_r;
  logic [`TAP_MSB-`TAP_LSB:0] tap;

  assign fen      = divider_control_reg_i[`DIV_EN_BIT];
  assign tap      = divider_control_reg_i[`TAP_MSB:`TAP_LSB];
  assign fin_rise = src_pick(fdiv_src_sel_i, src_r) & !fin_lvl_r;

  // input edge and enable edge tracking
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fin_lvl_r <= 1'b0;
      fen_r     <= 1'b0;
    end
    else
    begin
      fin_lvl_r <= src_pick(fdiv_src_sel_i, src_r);
      fen_r     <= fen;
    end
  end

  // chained halving stages as a ripple count
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      chain_r <= '0;
      frun_r  <= 1'b0;
    end
    else if (fen && !fen_r)
    begin
      chain_r <= '0;
      frun_r  <= 1'b1;
    end
    else if (frun_r)
    begin
      if (!fen && !chain_r[tap])
        frun_r <= 1'b0;
      else if (fin_rise)
        chain_r <= chain_r + 1'b1;
    end
  end

  // tap multiplexer to the output pin
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      fdiv_out_o <= 1'b0;
    else
      fdiv_out_o <= frun_r & chain_r[tap];
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  pd_entry_only_a: assert property (
    $rose(pwr_down_o) |-> $past(pwr_down_bit_i) &&
      ($past(wait_for_interrupt_instr_i) || $past(wait_for_event_instr_i)))
    else $error("power-down entered without request");

  fast_src_off_a: assert property (
    pwr_down_o |=> !x12_en_o && !o22_en_o)
    else $error("fast source running in power-down");

  slow_src_on_a: assert property (
    pwr_down_o |=> x32_en_o && o10_en_o)
    else $error("slow source stopped in power-down");

  sys_clk_off_a: assert property (
    pwr_down_o |=> !sys_clk_o)
    else $error("system clock running in power-down");

  mod_keep_a: assert property (
    pwr_down_o && (mod_clk_en_i & ~(KEEP_MASK[MOD_NUM-1:0] & mod_slow_src_i)) != '0
      |=> (mod_clk_en_o & $past(mod_clk_en_i & ~(KEEP_MASK[MOD_NUM-1:0] & mod_slow_src_i)))
          == '0)
    else $error("module clock kept in power-down");

  mod_gate_a: assert property (
    !pwr_down_o |=> mod_clk_en_o == $past(mod_clk_en_i))
    else $error("module clock gate mismatch");

  fdiv_restart_a: assert property (
    fen && !fen_r |=> chain_r == '0 && frun_r ##1 !fdiv_out_o)
    else $error("divider not restarted on enable");

  fdiv_hold_a: assert property (
    !frun_r && !(fen && !fen_r) |=> !fdiv_out_o)
    else $error("divider output not held low");

  fdiv_tap_a: assert property (
    frun_r |=> fdiv_out_o == $past(chain_r[tap]))
    else $error("divider tap mismatch");

  fdiv_stop_a: assert property (
    frun_r && !fen && !chain_r[tap] |=> !frun_r)
    else $error("divider kept running after low output");

  tick_pd_a: assert property (
    pwr_down_o && !src_slow(tick_sel) |=> !tick_clock_o)
    else $error("tick clock running on fast source in power-down");

  pll_ref_a: assert property (
    1'b1 |=> pll_ref_o == $past(pll_ref_sel_i))
    else $error("pll reference select mismatch");

endmodule : clock_controller_freq_divider

// file: rtl/clkctl_params.svh
`ifndef CLKCTL_PARAMS_SVH
`define CLKCTL_PARAMS_SVH
// ----------------------------------------------------------------
// source count and source bit positions
// ----------------------------------------------------------------
`define SRC_NUM       5
`define SRC_X32       0
`define SRC_X12       1
`define SRC_PLL       2
`define SRC_O22       3
`define SRC_O10       4
// ----------------------------------------------------------------
// clock select register 0 fields
// ----------------------------------------------------------------
`define SYS_SEL_MSB   2
`define SYS_SEL_LSB   0
`define TICK_SEL_MSB  5
`define TICK_SEL_LSB  3
`define SEL0_W        6
// ----------------------------------------------------------------
// divider control register fields
// ----------------------------------------------------------------
`define TAP_MSB       3
`define TAP_LSB       0
`define DIV_EN_BIT    4
`define FDIV_CTRL_W   5
`define FDIV_STAGES   16
`define HDIV_W        4
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PLL_REF_X12   1'b0
`define SYNC_RST      3'h0
`endif

// file: rtl/clkctl_pkg.sv
package clkctl_pkg;
  // power state, gray order
  typedef enum logic [0:0] {
    PWR_RUN  = 1'b0,
    PWR_DOWN = 1'b1
  } pwr_state_t;
  typedef logic [2:0] src_sel_t;
endpackage : clkctl_pkg

// file: bench/clock_controller_freq_divider_tb_top.sv
`timescale 1ns/1ps
module clock_controller_freq_divider_tb_top;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic       clk_i   = 1'b0;
  logic       rstn_i  = 1'b0;
  logic [4:0] src     = 5'h00;
  logic       pref_i  = 1'b0;
  logic [5:0] sel0    = 6'h00;
  logic [3:0] sdiv    = 4'h0;
  logic [7:0] men     = 8'h00;
  logic [7:0] mslow   = 8'h00;
  logic       pdb     = 1'b0;
  logic       wint    = 1'b0;
  logic       wevt    = 1'b0;
  logic [2:0] divider_tap_select    = 3'h0;
  int         fb      = 1;
  logic       wake    = 1'b0;
  logic [4:0] fctl    = 5'h00;
  wire        x32, x12, pll, o22, o10, pref, sclk, tick, pd, fout;
  wire  [7:0] mout;
  int         bad_count, n_checks, rise_cnt, tcnt, ts;
  bit         run_src;
  logic       fout_q, sclk_q;
  int         per_q[$];
  logic [2:0] codes[6] = '{3'h1, 3'h0, 3'h2, 3'h7, 3'h3, 3'h4};

  always #10 clk_i = ~clk_i;

  clock_controller_freq_divider i_clock_controller_freq_divider (
    .clk_i(clk_i), .rstn_i(rstn_i), .src_lvl_i(src), .pll_ref_sel_i(pref_i),
    .clock_select_reg0_i(sel0), .sys_div_i(sdiv), .mod_clk_en_i(men),
    .mod_slow_src_i(mslow), .pwr_down_bit_i(pdb), .wait_for_interrupt_instr_i(wint),
    .wait_for_event_instr_i(wevt), .wake_i(wake), .divider_control_reg_i(fctl),
    .fdiv_src_sel_i(divider_tap_select), .x32_en_o(x32), .x12_en_o(x12), .pll_en_o(pll),
    .o22_en_o(o22), .o10_en_o(o10), .pll_ref_o(pref), .sys_clk_o(sclk),
    .tick_clock_o(tick), .mod_clk_en_o(mout), .pwr_down_o(pd), .fdiv_out_o(fout));

  // chosen source bit toggles every 6 cycles, rises counted
  always @(negedge clk_i)
    if (run_src)
    begin
      tcnt++;
      if (tcnt % 6 == 0)
      begin
        src[fb] = ~src[fb];
        if (src[fb])
          rise_cnt++;
      end
    end

  // source rises between divider output rises, system clock edges
  always @(posedge clk_i)
  begin
    if (fout === 1'b1 && fout_q !== 1'b1)
    begin
      per_q.push_back(rise_cnt);
      rise_cnt = 0;
    end
    if (sclk !== sclk_q)
      ts++;
    fout_q = fout;
    sclk_q = sclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  // watchdog
  initial
  begin
    #(30000 * 20);
    bad_count++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(32'ha0e8b1ae));
    repeat (12) @(posedge clk_i);
    check({x32, x12, pll, o22, o10}, 5'h1f);
    check({sclk, tick, pd, fout, mout}, 12'h000);
    @(negedge clk_i) rstn_i = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      @(negedge clk_i) pref_i = i[0];
      @(negedge clk_i) check(pref, i[0]);
    end
    for (int i = 0; i < 6; i++)
    begin
      @(negedge clk_i);
      src = 5'($urandom);
      sel0[5:3] = codes[i];
      repeat (8) @(negedge clk_i);
      check(tick, i < 5 ? src[i] : 1'b0);
    end
    repeat (4)
    begin
      @(negedge clk_i);
      men = 8'($urandom);
      mslow = 8'($urandom);
      @(negedge clk_i) check(mout, men);
    end
    run_src = 1'b1;
    sel0 = 6'h00;
    foreach (codes[d])
    begin
      sdiv = (d == 5) ? 4'($urandom % 2) : 4'(d % 4);
      repeat (40) @(negedge clk_i);
      ts = 0;
      repeat (240) @(negedge clk_i);
      check(ts * (sdiv + 1) inside {[39 - sdiv:41 + sdiv]}, 1'b1);
    end
    for (int k = 0; k < 2; k++)
    begin
      sel0[5:3] = k ? 3'h3 : 3'h0;
      @(negedge clk_i) {wevt, wint} = 2'b01 << k;
      @(negedge clk_i) {wevt, wint} = 2'b00;
      check(pd, 1'b0);
      @(negedge clk_i) pdb = 1'b1;
      {wevt, wint} = 2'b01 << k;
      @(negedge clk_i) {wevt, wint} = 2'b00;
      check(pd, 1'b1);
      repeat (30)
      begin
        @(negedge clk_i) check({x32, x12, pll, o22, o10}, 5'h11);
        check({sclk, tick}, {1'b0, k ? src[4] : 1'b0});
        check(mout, men & mslow & 8'h1f);
      end
      @(negedge clk_i) {wake, pdb} = 2'b10;
      @(negedge clk_i) wake = 1'b0;
      @(negedge clk_i) check(pd, 1'b0);
      @(negedge clk_i) check({x32, x12, pll, o22, o10}, 5'h1f);
    end
    for (int j = 0; j < 4; j++)
    begin
      int n;
      n = (j == 3) ? int'($urandom % 5) : j * 2;
      run_src = 1'b0;
      fb = j;
      divider_tap_select = codes[j];
      @(negedge clk_i) src[fb] = 1'b0;
      fctl = {1'b0, 4'(n)};
      repeat (8) @(negedge clk_i);
      fctl[4] = 1'b1;
      repeat (8) @(negedge clk_i);
      per_q.delete();
      rise_cnt = 0;
      run_src = 1'b1;
      for (int t = 0; t < 3000 && per_q.size() < 3; t++)
        @(negedge clk_i);
      fctl[4] = 1'b0;
      check(per_q[0], 1 << n);
      check(per_q[1], 2 << n);
      check(per_q[2], 2 << n);
      repeat (2) @(negedge clk_i);
      check(fout, 1'b1);
      repeat ((2 << n) * 12 + 20) @(negedge clk_i);
      repeat (8)
      begin
        repeat (12) @(negedge clk_i);
        check(fout, 1'b0);
      end
    end
    print_verdict();
  end
endmodule : clock_controller_freq_divider_tb_top
